//--- common/wwfb_defs.svh
// Offsets, field positions, reset values and frame constants of the frame bridge.
`ifndef WWFB_DEFS_SVH
`define WWFB_DEFS_SVH

// Register byte offsets on the bus.
`define WWFB_OFS_CTRL 8'h00
`define WWFB_OFS_BADDR_LO 8'h04
`define WWFB_OFS_BADDR_HI 8'h08
`define WWFB_OFS_WIRED_MAC_LO 8'h0c
`define WWFB_OFS_WIRED_MAC_HI 8'h10
`define WWFB_OFS_WLESS_MAC_LO 8'h14
`define WWFB_OFS_WLESS_MAC_HI 8'h18
`define WWFB_OFS_WIRED_IP 8'h1c
`define WWFB_OFS_WLESS_IP 8'h20
`define WWFB_OFS_STATUS 8'h24
`define WWFB_OFS_EFF_LO 8'h28
`define WWFB_OFS_EFF_HI 8'h2c

// Control register fields.
`define WWFB_CTRL_EN_BIT 0
`define WWFB_CTRL_PRE_BIT 1
`define WWFB_CTRL_REBOOT_BIT 8

// Status register fields.
`define WWFB_ST_ACTIVE_BIT 0
`define WWFB_ST_PRIM_WIRED_BIT 1
`define WWFB_ST_ADDR_VALID_BIT 2
`define WWFB_ST_EN_BIT 3
`define WWFB_ST_WIRED_UP_BIT 4
`define WWFB_ST_WLESS_UP_BIT 5
`define WWFB_ST_LEARNED_BIT 6

// Reset values.
`define WWFB_RST_WORD 32'h0000_0000
`define WWFB_RST_ADDR 48'h0000_0000_0000

// Frame constants.
`define WWFB_ETYPE_ARP 16'h0806
`define WWFB_ARP_OPER_REQ 16'h0001

// Bus encodings.
`define WWFB_HTRANS_NONSEQ_BIT 1
`define WWFB_HRESP_OKAY 1'b0

`endif

//--- common/wwfb_pkg.sv
// Types shared by the frame bridge modules.
package wwfb_pkg;

   // Header summary of one frame, carried with each frame handle.
   typedef struct packed {
      logic [47:0] dst;
      logic [47:0] src;
      logic [15:0] ethertype;
      logic [15:0] arp_oper;
      logic [31:0] arp_tpa;
      logic [15:0] handle;
   } wwfb_frame_t;

   // Where an accepted frame goes.
   typedef enum logic [2:0] {
      WWFB_V_FWD = 3'b001,
      WWFB_V_LOCAL = 3'b010,
      WWFB_V_DROP = 3'b100
   } wwfb_verdict_t;

   // Bridge state.
   typedef enum logic [1:0] {
      WWFB_INACTIVE = 2'b01,
      WWFB_ACTIVE = 2'b10
   } wwfb_state_t;

endpackage : wwfb_pkg

//--- rtl/wwfb_fwd_slot.sv
// One-entry frame slot that steers an accepted frame to the far port or to local services.
module wwfb_fwd_slot
   import wwfb_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic arst_n_in,
   input wire logic in_valid_in,
   input wire wwfb_frame_t in_frame_in,
   input wire wwfb_verdict_t verdict_in,
   output logic in_ready_out,
   output logic fwd_valid_out,
   output wwfb_frame_t fwd_frame_out,
   input wire logic fwd_ready_in,
   output logic loc_valid_out,
   output wwfb_frame_t loc_frame_out,
   input wire logic loc_ready_in
);

   logic take;
   logic fwd_go;
   logic loc_go;
   logic fwd_busy_nxt;
   logic loc_busy_nxt;

   // A frame is taken only when the slot has room; dropped frames leave no trace.
   assign take = in_valid_in & in_ready_out;
   assign fwd_go = take & (verdict_in == WWFB_V_FWD);
   assign loc_go = take & (verdict_in == WWFB_V_LOCAL);
   assign fwd_busy_nxt = fwd_go | (fwd_valid_out & ~fwd_ready_in);
   assign loc_busy_nxt = loc_go | (loc_valid_out & ~loc_ready_in);

   // Valid flags hold until the consumer takes the frame.
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         fwd_valid_out <= 1'b0;
         loc_valid_out <= 1'b0;
         in_ready_out <= 1'b0;
      end else begin
         fwd_valid_out <= fwd_busy_nxt;
         loc_valid_out <= loc_busy_nxt;
         in_ready_out <= ~(fwd_busy_nxt | loc_busy_nxt);
      end
   end

   // Frame data registers load only on a take.
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         fwd_frame_out <= '0;
         loc_frame_out <= '0;
      end else begin
         if (fwd_go) begin
            fwd_frame_out <= in_frame_in;
         end
         if (loc_go) begin
            loc_frame_out <= in_frame_in;
         end
      end
   end

endmodule : wwfb_fwd_slot

//--- rtl/wwfb_bridge.sv
// Wired to wireless frame bridge with primary port selection and bus registers.
`include "wwfb_defs.svh"

module wwfb_bridge
   import wwfb_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic arst_n_in,
   // Bus slave.
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   // Link states.
   input wire logic wired_link_up_in,
   input wire logic wireless_link_up_in,
   // Frames received on the wired port.
   input wire logic wired_rx_valid_in,
   input wire wwfb_frame_t wired_rx_frame_in,
   output logic wired_rx_ready_out,
   // Frames received on the wireless port.
   input wire logic wless_rx_valid_in,
   input wire wwfb_frame_t wless_rx_frame_in,
   output logic wless_rx_ready_out,
   // Frames sent out the wireless port.
   output logic wless_tx_valid_out,
   output wwfb_frame_t wless_tx_frame_out,
   input wire logic wless_tx_ready_in,
   // Frames sent out the wired port.
   output logic wired_tx_valid_out,
   output wwfb_frame_t wired_tx_frame_out,
   input wire logic wired_tx_ready_in,
   // Frames for local services, per receiving port.
   output logic wired_loc_valid_out,
   output wwfb_frame_t wired_loc_frame_out,
   input wire logic wired_loc_ready_in,
   output logic wless_loc_valid_out,
   output wwfb_frame_t wless_loc_frame_out,
   input wire logic wless_loc_ready_in,
   // Port state shown to the rest of the device.
   output logic bridge_active_out,
   output logic primary_is_wired_out,
   output logic [47:0] wless_station_addr_out,
   output logic [31:0] primary_ip_out,
   output logic [47:0] primary_mac_out,
   output logic primary_cfg_apply_out
);

   // Software-written registers; bridge enable and address are pending until reboot.
   logic cfg_en_r;
   logic cfg_pre_r;
   logic [47:0] cfg_baddr_r;
   logic [47:0] wired_mac_r;
   logic [47:0] wless_mac_r;
   logic [31:0] wired_ip_r;
   logic [31:0] wless_ip_r;
   logic reboot_r;
   // Values in force since the last reboot.
   logic boot_r;
   logic eff_en_r;
   logic eff_pre_r;
   logic learned_r;
   logic [47:0] baddr_r;
   logic addr_valid;
   // Bridge state and port selection.
   wwfb_state_t state_r;
   wwfb_state_t state_nxt;
   logic prim_wired_nxt;
   // Bus pipeline.
   logic wr_pend_r;
   logic [7:0] wr_addr_r;
   logic addr_phase;
   logic [31:0] rd_nxt;
   logic [31:0] status_word;
   // Frame steering.
   wwfb_verdict_t wired_verdict;
   wwfb_verdict_t wless_verdict;
   logic wired_take;
   logic learn_now;

   assign addr_valid = eff_pre_r | learned_r;
   assign wired_take = wired_rx_valid_in & wired_rx_ready_out;

   // Reboot reloads pending settings; a fresh reset counts as a reboot.
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         boot_r <= 1'b1;
      end else begin
         boot_r <= 1'b0;
      end
   end

   // Effective enable and preconfig flag change only at reboot.
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         eff_en_r <= 1'b0;
         eff_pre_r <= 1'b0;
      end else if (boot_r | reboot_r) begin
         eff_en_r <= cfg_en_r;
         eff_pre_r <= cfg_pre_r;
      end
   end

   // The first wired frame taken with bridging enabled supplies the address when none is preconfigured.
   assign learn_now = eff_en_r & ~eff_pre_r & ~learned_r & wired_take;

   // Bridge address: loaded at reboot, or learned once and then frozen.
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         baddr_r <= `WWFB_RST_ADDR;
         learned_r <= 1'b0;
      end else if (boot_r | reboot_r) begin
         baddr_r <= cfg_baddr_r;
         learned_r <= 1'b0;
      end else if (learn_now) begin
         baddr_r <= wired_rx_frame_in.src;
         learned_r <= 1'b1;
      end
   end

   // Active needs enable, both links and an address; a lost link drops it at once.
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         WWFB_INACTIVE: begin
            if (eff_en_r & wired_link_up_in & wireless_link_up_in & addr_valid) begin
               state_nxt = WWFB_ACTIVE;
            end
         end
         WWFB_ACTIVE: begin
            if (~wired_link_up_in | ~wireless_link_up_in | ~eff_en_r) begin
               state_nxt = WWFB_INACTIVE;
            end
         end
         default: begin
            state_nxt = WWFB_INACTIVE;
         end
      endcase
      if (reboot_r) begin
         state_nxt = WWFB_INACTIVE;
      end
   end

   // With bridging off the wired port is fixed as primary and never switches.
   assign prim_wired_nxt = eff_en_r ? wired_link_up_in : 1'b1;

   // State register and the port-state outputs.
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_r <= WWFB_INACTIVE;
         bridge_active_out <= 1'b0;
         primary_is_wired_out <= 1'b1;
         primary_cfg_apply_out <= 1'b0;
      end else begin
         state_r <= state_nxt;
         bridge_active_out <= (state_nxt == WWFB_ACTIVE);
         primary_is_wired_out <= prim_wired_nxt;
         primary_cfg_apply_out <= (prim_wired_nxt != primary_is_wired_out) | boot_r;
      end
   end

   // Primary port's own interface settings follow the primary selection.
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         primary_ip_out <= `WWFB_RST_WORD;
         primary_mac_out <= `WWFB_RST_ADDR;
         wless_station_addr_out <= `WWFB_RST_ADDR;
      end else begin
         primary_ip_out <= prim_wired_nxt ? wired_ip_r : wless_ip_r;
         primary_mac_out <= prim_wired_nxt ? wired_mac_r : wless_mac_r;
         wless_station_addr_out <= (state_nxt == WWFB_ACTIVE) ? baddr_r : wless_mac_r;
      end
   end

   // Wired frame verdict: while active local hits first, foreign sources dropped, rest bridged; else local only if wired is primary.
   always_comb begin
      wired_verdict = WWFB_V_DROP;
      if (!eff_en_r) begin
         wired_verdict = WWFB_V_LOCAL;
      end else if (state_r == WWFB_ACTIVE) begin
         if (wired_rx_frame_in.dst == wired_mac_r) begin
            wired_verdict = WWFB_V_LOCAL;
         end else if (wired_rx_frame_in.ethertype == `WWFB_ETYPE_ARP
                      && wired_rx_frame_in.arp_oper == `WWFB_ARP_OPER_REQ
                      && wired_rx_frame_in.arp_tpa == primary_ip_out) begin
            wired_verdict = WWFB_V_LOCAL;
         end else if (wired_rx_frame_in.src != baddr_r) begin
            wired_verdict = WWFB_V_DROP;
         end else begin
            wired_verdict = WWFB_V_FWD;
         end
      end else if (primary_is_wired_out) begin
         wired_verdict = WWFB_V_LOCAL;
      end
   end

   // Wireless frame verdict: all bridged while active, all local with bridging off, else primary services only.
   always_comb begin
      wless_verdict = WWFB_V_DROP;
      if (!eff_en_r) begin
         wless_verdict = WWFB_V_LOCAL;
      end else if (state_r == WWFB_ACTIVE) begin
         wless_verdict = WWFB_V_FWD;
      end else if (!primary_is_wired_out) begin
         wless_verdict = WWFB_V_LOCAL;
      end
   end

   // Wired receive path.
   wwfb_fwd_slot u_wired_slot (
      .clk_sys_in(clk_sys_in),
      .arst_n_in(arst_n_in),
      .in_valid_in(wired_rx_valid_in),
      .in_frame_in(wired_rx_frame_in),
      .verdict_in(wired_verdict),
      .in_ready_out(wired_rx_ready_out),
      .fwd_valid_out(wless_tx_valid_out),
      .fwd_frame_out(wless_tx_frame_out),
      .fwd_ready_in(wless_tx_ready_in),
      .loc_valid_out(wired_loc_valid_out),
      .loc_frame_out(wired_loc_frame_out),
      .loc_ready_in(wired_loc_ready_in)
   );

   // Wireless receive path.
   wwfb_fwd_slot u_wless_slot (
      .clk_sys_in(clk_sys_in),
      .arst_n_in(arst_n_in),
      .in_valid_in(wless_rx_valid_in),
      .in_frame_in(wless_rx_frame_in),
      .verdict_in(wless_verdict),
      .in_ready_out(wless_rx_ready_out),
      .fwd_valid_out(wired_tx_valid_out),
      .fwd_frame_out(wired_tx_frame_out),
      .fwd_ready_in(wired_tx_ready_in),
      .loc_valid_out(wless_loc_valid_out),
      .loc_frame_out(wless_loc_frame_out),
      .loc_ready_in(wless_loc_ready_in)
   );

   // Bus address phase: a selected NONSEQ or SEQ transfer while the bus is ready.
   assign addr_phase = hsel_in & htrans_in[`WWFB_HTRANS_NONSEQ_BIT] & hready_in;

   // Status word shows the bridge's own state.
   always_comb begin
      status_word = `WWFB_RST_WORD;
      status_word[`WWFB_ST_ACTIVE_BIT] = (state_r == WWFB_ACTIVE);
      status_word[`WWFB_ST_PRIM_WIRED_BIT] = primary_is_wired_out;
      status_word[`WWFB_ST_ADDR_VALID_BIT] = addr_valid;
      status_word[`WWFB_ST_EN_BIT] = eff_en_r;
      status_word[`WWFB_ST_WIRED_UP_BIT] = wired_link_up_in;
      status_word[`WWFB_ST_WLESS_UP_BIT] = wireless_link_up_in;
      status_word[`WWFB_ST_LEARNED_BIT] = learned_r;
   end

   // Read mux; unmapped offsets read as zero.
   always_comb begin
      rd_nxt = `WWFB_RST_WORD;
      unique case (haddr_in[7:0])
         `WWFB_OFS_CTRL: begin
            rd_nxt[`WWFB_CTRL_EN_BIT] = cfg_en_r;
            rd_nxt[`WWFB_CTRL_PRE_BIT] = cfg_pre_r;
         end
         `WWFB_OFS_BADDR_LO: rd_nxt = cfg_baddr_r[31:0];
         `WWFB_OFS_BADDR_HI: rd_nxt[15:0] = cfg_baddr_r[47:32];
         `WWFB_OFS_WIRED_MAC_LO: rd_nxt = wired_mac_r[31:0];
         `WWFB_OFS_WIRED_MAC_HI: rd_nxt[15:0] = wired_mac_r[47:32];
         `WWFB_OFS_WLESS_MAC_LO: rd_nxt = wless_mac_r[31:0];
         `WWFB_OFS_WLESS_MAC_HI: rd_nxt[15:0] = wless_mac_r[47:32];
         `WWFB_OFS_WIRED_IP: rd_nxt = wired_ip_r;
         `WWFB_OFS_WLESS_IP: rd_nxt = wless_ip_r;
         `WWFB_OFS_STATUS: rd_nxt = status_word;
         `WWFB_OFS_EFF_LO: rd_nxt = addr_valid ? baddr_r[31:0] : `WWFB_RST_WORD;
         `WWFB_OFS_EFF_HI: rd_nxt[15:0] = addr_valid ? baddr_r[47:32] : 16'h0000;
         default: rd_nxt = `WWFB_RST_WORD;
      endcase
      if (haddr_in[31:8] != 24'h00_0000) begin
         rd_nxt = `WWFB_RST_WORD;
      end
   end

   // Zero-wait slave: read data registered in the address phase, write taken in data phase.
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         hrdata_out <= `WWFB_RST_WORD;
         hreadyout_out <= 1'b1;
         hresp_out <= `WWFB_HRESP_OKAY;
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
      end else begin
         hreadyout_out <= 1'b1;
         hresp_out <= `WWFB_HRESP_OKAY;
         wr_pend_r <= addr_phase & hwrite_in & (haddr_in[31:8] == 24'h00_0000);
         if (addr_phase) begin
            wr_addr_r <= haddr_in[7:0];
            if (!hwrite_in) begin
               hrdata_out <= rd_nxt;
            end
         end
      end
   end

   // Register writes; the reboot bit is a self-clearing command.
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cfg_en_r <= 1'b0;
         cfg_pre_r <= 1'b0;
         cfg_baddr_r <= `WWFB_RST_ADDR;
         wired_mac_r <= `WWFB_RST_ADDR;
         wless_mac_r <= `WWFB_RST_ADDR;
         wired_ip_r <= `WWFB_RST_WORD;
         wless_ip_r <= `WWFB_RST_WORD;
         reboot_r <= 1'b0;
      end else begin
         reboot_r <= 1'b0;
         if (wr_pend_r) begin
            unique case (wr_addr_r)
               `WWFB_OFS_CTRL: begin
                  cfg_en_r <= hwdata_in[`WWFB_CTRL_EN_BIT];
                  cfg_pre_r <= hwdata_in[`WWFB_CTRL_PRE_BIT];
                  reboot_r <= hwdata_in[`WWFB_CTRL_REBOOT_BIT];
               end
               `WWFB_OFS_BADDR_LO: cfg_baddr_r[31:0] <= hwdata_in;
               `WWFB_OFS_BADDR_HI: cfg_baddr_r[47:32] <= hwdata_in[15:0];
               `WWFB_OFS_WIRED_MAC_LO: wired_mac_r[31:0] <= hwdata_in;
               `WWFB_OFS_WIRED_MAC_HI: wired_mac_r[47:32] <= hwdata_in[15:0];
               `WWFB_OFS_WLESS_MAC_LO: wless_mac_r[31:0] <= hwdata_in;
               `WWFB_OFS_WLESS_MAC_HI: wless_mac_r[47:32] <= hwdata_in[15:0];
               `WWFB_OFS_WIRED_IP: wired_ip_r <= hwdata_in;
               `WWFB_OFS_WLESS_IP: wless_ip_r <= hwdata_in;
               default: begin
               end
            endcase
         end
      end
   end

endmodule : wwfb_bridge

//--- tb/wwfb_checker.sv
// Concurrent checks on the ports of the frame bridge.
`include "wwfb_defs.svh"

module wwfb_checker
   import wwfb_pkg::*;
(
   input logic clk_sys_in,
   input logic arst_n_in,
   input logic wired_link_up_in,
   input logic wireless_link_up_in,
   input logic wired_rx_valid_in,
   input wwfb_frame_t wired_rx_frame_in,
   input logic wired_rx_ready_out,
   input logic wless_rx_valid_in,
   input wwfb_frame_t wless_rx_frame_in,
   input logic wless_rx_ready_out,
   input logic wless_tx_valid_out,
   input wwfb_frame_t wless_tx_frame_out,
   input logic wless_tx_ready_in,
   input logic wired_tx_valid_out,
   input wwfb_frame_t wired_tx_frame_out,
   input logic wired_loc_valid_out,
   input logic bridge_active_out,
   input logic primary_is_wired_out,
   input logic [47:0] wless_station_addr_out,
   input logic [31:0] primary_ip_out,
   input logic [47:0] primary_mac_out,
   input logic primary_cfg_apply_out
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!arst_n_in);
   logic both_up;
   logic wtake;
   logic is_arp;
   // Helper terms.
   assign both_up = wired_link_up_in && wireless_link_up_in;
   assign wtake = wired_rx_valid_in && wired_rx_ready_out && bridge_active_out;
   assign is_arp = wired_rx_frame_in.ethertype == `WWFB_ETYPE_ARP &&
      wired_rx_frame_in.arp_oper == `WWFB_ARP_OPER_REQ && wired_rx_frame_in.arp_tpa == primary_ip_out;

   AST_PRIM_WIRED: assert property (bridge_active_out |-> primary_is_wired_out)
      else $error("active not wired primary");
   AST_PRIM_SWITCH: assert property ($fell(wired_link_up_in) && bridge_active_out
      |-> ##[1:2] !primary_is_wired_out) else $error("primary kept");
   AST_ENTER: assert property ($rose(bridge_active_out) |-> $past(both_up))
      else $error("bad entry");
   AST_LEAVE: assert property (bridge_active_out && !both_up |=> !bridge_active_out)
      else $error("no exit");
   AST_STA: assert property (bridge_active_out && $past(bridge_active_out)
      |-> $stable(wless_station_addr_out)) else $error("address moved");
   AST_FWD_ACT: assert property ($rose(wless_tx_valid_out) |-> $past(bridge_active_out))
      else $error("bridged inactive");
   AST_WLESS_FWD: assert property (wless_rx_valid_in && wless_rx_ready_out && bridge_active_out
      |=> wired_tx_valid_out && wired_tx_frame_out == $past(wless_rx_frame_in))
      else $error("wireless not bridged");
   AST_HOLD: assert property (wless_tx_valid_out && !wless_tx_ready_in
      |=> wless_tx_valid_out && $stable(wless_tx_frame_out)) else $error("frame not held");
   AST_OWN_MAC: assert property (wtake && primary_is_wired_out &&
      wired_rx_frame_in.dst == primary_mac_out |=> wired_loc_valid_out && !wless_tx_valid_out)
      else $error("own frame bridged");
   AST_ARP_LOCAL: assert property (wtake && primary_is_wired_out && is_arp
      |=> wired_loc_valid_out && !wless_tx_valid_out) else $error("request bridged");
   AST_APPLY: assert property ($changed(primary_is_wired_out)
      |-> ##[0:1] primary_cfg_apply_out) else $error("no apply");

   // Main scenarios reached.
   COV_ACTIVE: cover property ($rose(bridge_active_out));
   COV_WTAKE: cover property (wtake);
   COV_SWITCH: cover property ($fell(primary_is_wired_out));
endmodule : wwfb_checker

bind wwfb_bridge wwfb_checker i_wwfb_checker (.*);

//--- tb/wwfb_partner.sv
// Far side model that sinks the four outgoing frame streams.
module wwfb_partner
   import wwfb_pkg::*;
(
   input logic clk_sys_in,
   input logic arst_n_in,
   input logic slow_in,
   input logic [3:0] valid_in,
   input logic [3:0][15:0] handle_in,
   output logic [3:0] ready_out,
   output logic [7:0] cnt_out,
   output logic [1:0] port_out,
   output logic [15:0] handle_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // Ready toggles while slow.
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ready_out <= 4'h0;
      end else begin
         ready_out <= slow_in ? ~ready_out : 4'hf;
      end
   end
   // Logs delivered frames; several in one cycle count once, with the highest stream logged.
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cnt_out <= 8'h00;
         port_out <= 2'h0;
         handle_out <= 16'h0000;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (valid_in[i] && ready_out[i]) begin
               cnt_out <= cnt_out + 8'h01;
               port_out <= 2'(i);
               handle_out <= handle_in[i];
            end
         end
      end
   end
endmodule : wwfb_partner

//--- tb/testbench.sv
// Self-checking testbench of the frame bridge.
`include "wwfb_defs.svh"
module testbench
   import wwfb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys_in, arst_n_in, hsel, hwrite, hrdy, hresp, wup, lup, wrv, lrv, slow;
   logic wrdy, lrdy, act, prim, apply, m_en, m_pre, m_lrn;
   logic [1:0] htrans, pport;
   logic [31:0] haddr, hwdata, hrdata, pip, m_ip, m_wip;
   logic [47:0] sta, pmac, m_mac, m_ba;
   logic [3:0] pv, prdy;
   logic [7:0] pcnt;
   logic [15:0] phnd;
   wwfb_frame_t wrf, lrf, f;
   wwfb_frame_t fo [4];
   int error_cnt, n_tests;

   wwfb_bridge i_wwfb_bridge (
      .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .hsel_in(hsel), .haddr_in(haddr),
      .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
      .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp),
      .wired_link_up_in(wup), .wireless_link_up_in(lup), .wired_rx_valid_in(wrv),
      .wired_rx_frame_in(wrf), .wired_rx_ready_out(wrdy), .wless_rx_valid_in(lrv),
      .wless_rx_frame_in(lrf), .wless_rx_ready_out(lrdy), .wless_tx_valid_out(pv[0]),
      .wless_tx_frame_out(fo[0]), .wless_tx_ready_in(prdy[0]), .wired_tx_valid_out(pv[1]),
      .wired_tx_frame_out(fo[1]), .wired_tx_ready_in(prdy[1]), .wired_loc_valid_out(pv[2]),
      .wired_loc_frame_out(fo[2]), .wired_loc_ready_in(prdy[2]), .wless_loc_valid_out(pv[3]),
      .wless_loc_frame_out(fo[3]), .wless_loc_ready_in(prdy[3]), .bridge_active_out(act),
      .primary_is_wired_out(prim), .wless_station_addr_out(sta), .primary_ip_out(pip),
      .primary_mac_out(pmac), .primary_cfg_apply_out(apply));
   wwfb_partner i_wwfb_partner (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
      .slow_in(slow), .valid_in(pv), .handle_in({fo[3].handle, fo[2].handle, fo[1].handle,
      fo[0].handle}), .ready_out(prdy), .cnt_out(pcnt), .port_out(pport), .handle_out(phnd));

   // Clock of 50 ns period.
   initial begin
      clk_sys_in = 1'b0;
      forever #25 clk_sys_in = ~clk_sys_in;
   end

   task automatic conclude;
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : conclude

   task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
      n_tests++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // Single bus transfer; read data taken at the data phase edge.
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge clk_sys_in);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge clk_sys_in); while (hrdy !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk_sys_in); while (hrdy !== 1'b1);
      q = hrdata;
   endtask : bus

   // Register write; reboot reloads the model.
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
      if (a == `WWFB_OFS_CTRL && d[`WWFB_CTRL_REBOOT_BIT])
         {m_en, m_pre, m_lrn} = {d[0], d[1], 1'b0};
   endtask : wr

   task automatic rdc(input logic [31:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk("register read", 48'(e), 48'(q));
      chk("response", 48'h0, 48'(hresp));
   endtask : rdc

   // Expected status word.
   function automatic logic [31:0] st();
      logic v;
      v = m_en && (m_pre || m_lrn);
      return {25'h0, m_lrn, lup, wup, m_en, v, !m_en || wup, v && wup && lup};
   endfunction : st

   // Expected stream: 0 none, 1 wireless out, 2 wired out, 3 wired local, 4 wireless local.
   function automatic logic [2:0] route(input logic w, input wwfb_frame_t x);
      if (!m_en) return w ? 3'd3 : 3'd4;
      if (!(wup && lup && (m_pre || m_lrn))) return (w == wup) ? (w ? 3'd3 : 3'd4) : 3'd0;
      if (!w) return 3'd2;
      if (x.dst == m_mac) return 3'd3;
      if (x.ethertype == `WWFB_ETYPE_ARP && x.arp_oper == `WWFB_ARP_OPER_REQ &&
          x.arp_tpa == m_ip) return 3'd3;
      return (x.src == m_ba) ? 3'd1 : 3'd0;
   endfunction : route

   function automatic wwfb_frame_t rf();
      return 176'({$urandom, $urandom, $urandom, $urandom, $urandom, $urandom});
   endfunction : rf

   // Offers one frame and checks where it comes out.
   task automatic send(input logic w, input wwfb_frame_t x);
      logic [7:0] c0;
      logic [2:0] ex;
      ex = route(w, x);
      c0 = pcnt;
      @(posedge clk_sys_in);
      {wrv, lrv, wrf, lrf} <= {w, !w, x, x};
      do @(posedge clk_sys_in); while ((w ? wrdy : lrdy) !== 1'b1);
      {wrv, lrv} <= 2'b00;
      if (w && m_en && !m_pre && !m_lrn) begin
         m_ba = x.src;
         m_lrn = 1'b1;
      end
      for (int k = 0; k < 12 && pcnt == c0; k++) @(posedge clk_sys_in);
      chk("frame stream", 48'(ex), 48'(pcnt == c0 ? 3'd0 : 3'(pport) + 3'd1));
      if (ex != 3'd0) chk("frame handle", 48'(x.handle), 48'(phnd));
   endtask : send

   task automatic link(input logic w, input logic l);
      @(posedge clk_sys_in);
      wup <= w;
      lup <= l;
      repeat (4) @(posedge clk_sys_in);
   endtask : link

   // Watchdog against a hang.
   initial begin
      repeat (20000) @(posedge clk_sys_in);
      error_cnt++;
      conclude();
   end

   // Main sequence.
   initial begin
      void'($urandom(57));
      {arst_n_in, hsel, hwrite, wrv, lrv, slow, m_en, m_pre, m_lrn} = '0;
      {wup, lup, htrans, haddr, hwdata, wrf, lrf} = {2'b11, 2'b00, 64'h0, rf(), rf()};
      {m_mac, m_ba, m_ip, m_wip} = 160'({rf(), 16'h0});
      repeat (3) @(posedge clk_sys_in);
      arst_n_in <= 1'b1;
      rdc(`WWFB_OFS_STATUS, st());
      rdc(32'h124, 32'h0);
      send(1'b1, rf());
      send(1'b0, rf());
      wr(`WWFB_OFS_WIRED_MAC_LO, m_mac[31:0]);
      wr(`WWFB_OFS_WIRED_MAC_HI, {16'h0, m_mac[47:32]});
      wr(`WWFB_OFS_WIRED_IP, m_ip);
      wr(`WWFB_OFS_WLESS_IP, m_wip);
      wr(`WWFB_OFS_BADDR_LO, m_ba[31:0]);
      wr(`WWFB_OFS_BADDR_HI, {16'h0, m_ba[47:32]});
      wr(`WWFB_OFS_CTRL, 32'h3);
      rdc(`WWFB_OFS_STATUS, st());
      wr(`WWFB_OFS_CTRL, 32'h103);
      link(1'b1, 1'b1);
      chk("active", 48'h3, 48'({act, prim}));
      chk("station address", m_ba, sta);
      chk("primary address", 48'(m_ip), 48'(pip));
      rdc(`WWFB_OFS_EFF_LO, m_ba[31:0]);
      for (int i = 0; i < 15; i++) begin
         f = rf();
         slow <= 1'($urandom);
         case (i % 5)
            1: f.src = m_ba;
            2: f.dst = m_mac;
            3: begin
               f.ethertype = `WWFB_ETYPE_ARP;
               f.arp_oper = `WWFB_ARP_OPER_REQ;
               f.arp_tpa = m_ip;
            end
            default: ;
         endcase
         send(i % 5 != 0, f);
      end
      wr(`WWFB_OFS_CTRL, 32'h0);
      wr(`WWFB_OFS_BADDR_LO, ~m_ba[31:0]);
      rdc(`WWFB_OFS_EFF_LO, m_ba[31:0]);
      rdc(`WWFB_OFS_STATUS, st());
      link(1'b0, 1'b1);
      chk("inactive port state", 48'h0, 48'({act, prim}));
      chk("primary address", 48'(m_wip), 48'(pip));
      send(1'b1, rf());
      send(1'b0, rf());
      link(1'b1, 1'b0);
      send(1'b0, rf());
      link(1'b1, 1'b1);
      wr(`WWFB_OFS_CTRL, 32'h101);
      rdc(`WWFB_OFS_STATUS, st());
      send(1'b1, rf());
      rdc(`WWFB_OFS_EFF_LO, m_ba[31:0]);
      rdc(`WWFB_OFS_EFF_HI, {16'h0, m_ba[47:32]});
      send(1'b1, rf());
      f = rf();
      f.src = m_ba;
      send(1'b1, f);
      rdc(`WWFB_OFS_STATUS, st());
      conclude();
   end
endmodule : testbench
